// [include/sbn_defines.svh]
// Behaviour
// - Subtract accumulator and inverted carry, update flags
// - Subtract result goes to accumulator or operand
// - Bank bit picks access bank or bank_pointer
// - Upper bits 0011 10da decode as nibble_exchange
// - Nibbles swap, status flags stay unchanged
// - Swapped value to accumulator or operand register
`ifndef SBN_DEFINES_SVH
`define SBN_DEFINES_SVH

// Register byte offsets on the AXI4-Lite slave
`define SBN_OFS_INSTR 8'h00
`define SBN_OFS_ACC 8'h04
`define SBN_OFS_BANK 8'h08
`define SBN_OFS_STATUS 8'h0C
`define SBN_OFS_MADDR 8'h10
`define SBN_OFS_MDATA 8'h14

// Status register bit positions
`define SBN_ST_C 0
`define SBN_ST_DC 1
`define SBN_ST_Z 2
`define SBN_ST_OV 3
`define SBN_ST_N 4
`define SBN_ST_BUSY 8
`define SBN_ST_ILLEGAL 9

// Instruction word fields
`define SBN_OPC_HI 15
`define SBN_OPC_LO 10
`define SBN_BIT_D 9
`define SBN_BIT_A 8
`define SBN_OPC_SUBB 6'h16
`define SBN_OPC_SWAP 6'h0E

// Reset values
`define SBN_RST_BYTE 8'h00
`define SBN_RST_INSTR 16'h0000
`define SBN_RST_MADDR 12'h000

// AXI responses
`define SBN_RESP_OKAY 2'b00
`define SBN_RESP_SLVERR 2'b10

`endif

// [include/sbn_pkg.sv]
`include "sbn_defines.svh"
package sbn_pkg;

	// Instruction cycle phases; idle between instructions
	typedef enum logic [2:0] {
		SBN_IDLE,
		SBN_Q1,
		SBN_Q2,
		SBN_Q3,
		SBN_Q4
	} sbn_phase_t;

	// Decoded operation
	typedef enum logic [1:0] {
		SBN_K_NONE,
		SBN_K_SUBB,
		SBN_K_SWAP
	} sbn_kind_t;

	// Arithmetic status flags
	typedef struct packed {
		logic n;
		logic ov;
		logic z;
		logic dc;
		logic c;
	} sbn_flags_t;

	// Write port of the file memory
	typedef struct packed {
		logic we;
		logic [11:0] addr;
		logic [7:0] data;
	} sbn_mem_wr_t;

	// Whole state of the execution block
	typedef struct packed {
		sbn_phase_t phase;
		sbn_kind_t kind;
		logic [15:0] instr;
		logic [7:0] acc;
		logic [3:0] bank;
		logic [11:0] op_addr;
		logic [7:0] operand;
		logic [7:0] result;
		sbn_flags_t flags;
		sbn_flags_t nflags;
		logic illegal;
		logic [11:0] maddr;
		logic aw_held;
		logic [7:0] awaddr;
		logic w_held;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} sbn_state_t;

endpackage : sbn_pkg

// [rtl/sbn_file_ram.sv]
module sbn_file_ram #(
	parameter int DEPTH = 4096
) (
	// Clock
	input wire logic aclk,
	// Write port
	input wire sbn_pkg::sbn_mem_wr_t wr,
	// Read ports: execution and software
	input wire logic [11:0] raddr_a,
	output logic [7:0] rdata_a,
	input wire logic [11:0] raddr_b,
	output logic [7:0] rdata_b
);
	import sbn_pkg::*;

	logic [7:0] mem [DEPTH];

	// Asynchronous reads keep the operand read inside one phase
	assign rdata_a = (32'(raddr_a) < DEPTH) ? mem[raddr_a] : 8'h00;
	assign rdata_b = (32'(raddr_b) < DEPTH) ? mem[raddr_b] : 8'h00;

	// Single write port; contents are not cleared by reset
	always_ff @(posedge aclk) begin
		if (wr.we && (32'(wr.addr) < DEPTH)) begin
			mem[wr.addr] <= wr.data;
		end
	end

endmodule : sbn_file_ram

// [rtl/sbn_exec.sv]
`include "sbn_defines.svh"
module sbn_exec #(
	parameter int DEPTH = 4096,
	parameter logic [3:0] ACCESS_BANK = 4'h0
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address
	input wire logic awvalid,
	output logic awready,
	input wire logic [7:0] awaddr,
	input wire logic [2:0] awprot,
	// AXI4-Lite write data
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// AXI4-Lite write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// AXI4-Lite read address
	input wire logic arvalid,
	output logic arready,
	input wire logic [7:0] araddr,
	input wire logic [2:0] arprot,
	// AXI4-Lite read data
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp
);
	import sbn_pkg::*;

	sbn_state_t s_q;
	sbn_state_t s_d;
	sbn_mem_wr_t mwr;
	logic [7:0] rd_exec;
	logic [7:0] rd_sw;

	// Merge one byte lane under its strobe
	function automatic logic [7:0] lane(input logic [7:0] old, input logic [7:0] nw,
		input logic en);
		lane = en ? nw : old;
	endfunction : lane

	// Subtract with borrow: f - acc - !c, carry set means no borrow
	function automatic sbn_flags_t subb_flags(input logic [7:0] f, input logic [7:0] w,
		input logic cin, output logic [7:0] res);
		logic [8:0] full;
		logic [4:0] low;
		full = {1'b0, f} - {1'b0, w} - {8'h00, ~cin};
		low = {1'b0, f[3:0]} - {1'b0, w[3:0]} - {4'h0, ~cin};
		res = full[7:0];
		subb_flags.c = ~full[8];
		subb_flags.dc = ~low[4];
		subb_flags.z = (full[7:0] == 8'h00);
		subb_flags.n = full[7];
		subb_flags.ov = (f[7] != w[7]) && (full[7] != f[7]);
	endfunction : subb_flags

	// Read-back value of a register
	function automatic logic [31:0] reg_value(input sbn_state_t s, input logic [7:0] a,
		input logic [7:0] mdat);
		logic [31:0] v;
		v = 32'h0000_0000;
		unique case (a)
			`SBN_OFS_INSTR: v = {16'h0000, s.instr};
			`SBN_OFS_ACC: v = {24'h00_0000, s.acc};
			`SBN_OFS_BANK: v = {28'h000_0000, s.bank};
			`SBN_OFS_STATUS: begin
				v[`SBN_ST_C] = s.flags.c;
				v[`SBN_ST_DC] = s.flags.dc;
				v[`SBN_ST_Z] = s.flags.z;
				v[`SBN_ST_OV] = s.flags.ov;
				v[`SBN_ST_N] = s.flags.n;
				v[`SBN_ST_BUSY] = (s.phase != SBN_IDLE);
				v[`SBN_ST_ILLEGAL] = s.illegal;
			end
			`SBN_OFS_MADDR: v = {20'h0_0000, s.maddr};
			`SBN_OFS_MDATA: v = {24'h00_0000, mdat};
			default: v = 32'h0000_0000;
		endcase
		reg_value = v;
	endfunction : reg_value

	// Known register offsets
	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == `SBN_OFS_INSTR) || (a == `SBN_OFS_ACC) || (a == `SBN_OFS_BANK) ||
			(a == `SBN_OFS_STATUS) || (a == `SBN_OFS_MADDR) || (a == `SBN_OFS_MDATA);
	endfunction : mapped

	sbn_file_ram #(
		.DEPTH(DEPTH)
	) u_ram (
		.aclk(aclk),
		.wr(mwr),
		.raddr_a(s_q.op_addr),
		.rdata_a(rd_exec),
		.raddr_b(s_q.maddr),
		.rdata_b(rd_sw)
	);

	// Next state: bus slave and the four-phase instruction cycle
	always_comb begin
		logic commit;
		logic idle;
		logic [7:0] res;
		sbn_flags_t f;
		commit = 1'b0;
		idle = (s_q.phase == SBN_IDLE);
		res = 8'h00;
		f = '0;
		s_d = s_q;
		mwr = '0;

		// Address and data are taken independently, in either order
		if (awvalid && s_q.awready) begin
			s_d.aw_held = 1'b1;
			s_d.awaddr = awaddr;
		end
		if (wvalid && s_q.wready) begin
			s_d.w_held = 1'b1;
			s_d.wdata = wdata;
			s_d.wstrb = wstrb;
		end
		if (s_q.bvalid && bready) begin
			s_d.bvalid = 1'b0;
		end

		// A write lands only when idle; busy or unmapped gives SLVERR
		if (s_q.aw_held && s_q.w_held && !s_q.bvalid) begin
			commit = idle && mapped(s_q.awaddr);
			s_d.aw_held = 1'b0;
			s_d.w_held = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = commit ? `SBN_RESP_OKAY : `SBN_RESP_SLVERR;
		end
		if (commit) begin
			unique case (s_q.awaddr)
				`SBN_OFS_INSTR: begin
					s_d.instr[7:0] = lane(s_q.instr[7:0], s_q.wdata[7:0], s_q.wstrb[0]);
					s_d.instr[15:8] = lane(s_q.instr[15:8], s_q.wdata[15:8], s_q.wstrb[1]);
					s_d.phase = SBN_Q1;
				end
				`SBN_OFS_ACC: s_d.acc = lane(s_q.acc, s_q.wdata[7:0], s_q.wstrb[0]);
				`SBN_OFS_BANK: begin
					if (s_q.wstrb[0]) begin
						s_d.bank = s_q.wdata[3:0];
					end
				end
				`SBN_OFS_STATUS: begin
					if (s_q.wstrb[0]) begin
						s_d.flags = s_q.wdata[4:0];
					end
				end
				`SBN_OFS_MADDR: begin
					s_d.maddr[7:0] = lane(s_q.maddr[7:0], s_q.wdata[7:0], s_q.wstrb[0]);
					if (s_q.wstrb[1]) begin
						s_d.maddr[11:8] = s_q.wdata[11:8];
					end
				end
				`SBN_OFS_MDATA: begin
					mwr.we = s_q.wstrb[0];
					mwr.addr = s_q.maddr;
					mwr.data = s_q.wdata[7:0];
				end
				default: ;
			endcase
		end

		// Read: one register access per address handshake
		if (arvalid && s_q.arready) begin
			s_d.arready = 1'b0;
			s_d.rvalid = 1'b1;
			s_d.rdata = reg_value(s_q, araddr, rd_sw);
			s_d.rresp = mapped(araddr) ? `SBN_RESP_OKAY : `SBN_RESP_SLVERR;
		end
		if (s_q.rvalid && rready) begin
			s_d.rvalid = 1'b0;
			s_d.arready = 1'b1;
		end

		// Instruction cycle, one phase per clock
		unique case (s_q.phase)
			SBN_IDLE: ;
			SBN_Q1: begin
				// Decode opcode and form the operand address
				if (s_q.instr[`SBN_OPC_HI:`SBN_OPC_LO] == `SBN_OPC_SUBB) begin
					s_d.kind = SBN_K_SUBB;
				end else if (s_q.instr[`SBN_OPC_HI:`SBN_OPC_LO] == `SBN_OPC_SWAP) begin
					s_d.kind = SBN_K_SWAP;
				end else begin
					s_d.kind = SBN_K_NONE;
				end
				s_d.illegal = (s_d.kind == SBN_K_NONE);
				s_d.op_addr = s_q.instr[`SBN_BIT_A] ? {s_q.bank, s_q.instr[7:0]} :
					{ACCESS_BANK, s_q.instr[7:0]};
				s_d.phase = SBN_Q2;
			end
			SBN_Q2: begin
				s_d.operand = rd_exec;
				s_d.phase = SBN_Q3;
			end
			SBN_Q3: begin
				// Compute now, commit in the last phase
				if (s_q.kind == SBN_K_SUBB) begin
					f = subb_flags(s_q.operand, s_q.acc, s_q.flags.c, res);
					s_d.nflags = f;
				end else begin
					res = {s_q.operand[3:0], s_q.operand[7:4]};
					s_d.nflags = s_q.flags;
				end
				s_d.result = res;
				s_d.phase = SBN_Q4;
			end
			SBN_Q4: begin
				// Undecoded words write nothing and keep the flags
				if (s_q.kind != SBN_K_NONE) begin
					if (!s_q.instr[`SBN_BIT_D]) begin
						s_d.acc = s_q.result;
					end else begin
						mwr.we = 1'b1;
						mwr.addr = s_q.op_addr;
						mwr.data = s_q.result;
					end
					s_d.flags = s_q.nflags;
				end
				s_d.phase = SBN_IDLE;
			end
		endcase

		// Ready is withheld while a half of the write is held
		s_d.awready = !s_d.aw_held && !s_d.bvalid;
		s_d.wready = !s_d.w_held && !s_d.bvalid;
	end

	// State register; synchronous reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '0;
			s_q.phase <= SBN_IDLE;
			s_q.kind <= SBN_K_NONE;
			s_q.instr <= `SBN_RST_INSTR;
			s_q.acc <= `SBN_RST_BYTE;
			s_q.maddr <= `SBN_RST_MADDR;
			s_q.awready <= 1'b1;
			s_q.wready <= 1'b1;
			s_q.arready <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// Bus outputs straight from the state register
	assign awready = s_q.awready;
	assign wready = s_q.wready;
	assign bvalid = s_q.bvalid;
	assign bresp = s_q.bresp;
	assign arready = s_q.arready;
	assign rvalid = s_q.rvalid;
	assign rdata = s_q.rdata;
	assign rresp = s_q.rresp;

endmodule : sbn_exec

// [dv/sbn_exec_checker.sv]
`include "sbn_defines.svh"
module sbn_exec_checker (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Write side
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [1:0] bresp,
	// Read side
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp
);
	timeunit 1ns;
	timeprecision 1ps;
	// One domain, so clock and reset are given once
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// Instruction words and operands only arrive through these handshakes
	AST_B_NEXT:
	// Both halves are held for one edge, then the commit edge raises bvalid
	assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
		else $error("no bvalid");
	AST_B_HOLD:
	assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("bvalid dropped");
	AST_R_NEXT:
	assert property (arvalid && arready |=> rvalid) else $error("no rvalid");
	AST_R_HOLD:
	assert property (rvalid && !rready |=> rvalid && $stable(rdata)) else $error("rdata moved");
	AST_ERR_ZERO:
	assert property (rvalid && rresp == `SBN_RESP_SLVERR |-> rdata == 32'h0000_0000)
		else $error("error read not zero");
	AST_AR_QUIET:
	assert property (rvalid |-> !arready) else $error("arready during read");
	AST_W_QUIET:
	assert property (bvalid |-> !awready && !wready) else $error("ready during response");
	AST_RDY_BACK:
	assert property (bvalid && bready |=> awready && wready && !bvalid) else $error("no ready");
	// Main traffic kinds
	cover property (bvalid && bready && bresp == `SBN_RESP_SLVERR);
	cover property (rvalid && rready);
	cover property (awvalid && awready && wvalid && wready);
endmodule : sbn_exec_checker

bind sbn_exec sbn_exec_checker i_sbn_exec_checker (.aclk(aclk), .aresetn(aresetn),
	.awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
	.bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
	.arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));

// [dv/tb_top.sv]
`include "sbn_defines.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// Bus wires
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, v;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, r;
	logic [11:0] ad;
	int err_count, check_count;
	// Row: instruction, acc, bank, status, operand, result, status after
	typedef struct {logic [15:0] i; logic [7:0] w, b, s, f, x, y;} sbn_row_t;
	sbn_row_t rows[6] = '{'{16'h5A10, 8'h0D, 8'h03, 8'h01, 8'h19, 8'h0C, 8'h01},
		'{16'h5811, 8'h1A, 8'h00, 8'h00, 8'h1B, 8'h00, 8'h07},
		'{16'h5B20, 8'h0E, 8'h03, 8'h01, 8'h03, 8'hF5, 8'h10},
		'{16'h5A12, 8'h01, 8'h00, 8'h01, 8'h80, 8'h7F, 8'h09},
		'{16'h3A13, 8'h00, 8'h00, 8'h1B, 8'h53, 8'h35, 8'h1B},
		'{16'h3921, 8'h77, 8'h02, 8'h04, 8'hA5, 8'h5A, 8'h04}};

	sbn_exec i_sbn_exec (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
		.awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
		.wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
		.arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
		.rdata(rdata), .rresp(rresp));

	// 40 MHz clock
	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			err_count++;
			$display("mismatch %0t data %h expected %h", $time, g, e);
		end
	endtask : chk

	task automatic chkr(input logic [1:0] g, input logic [1:0] e);
		check_count++;
		if (g !== e) begin
			err_count++;
			$display("mismatch %0t resp %b expected %b", $time, g, e);
		end
	endtask : chkr

	task automatic finish_test;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : finish_test

	task automatic tmo;
		err_count++;
		$display("mismatch %0t bus wait ran out", $time);
		finish_test();
	endtask : tmo

	// Handshakes judged at the falling edge, where ready is settled
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		logic ta, tw, tb;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(negedge aclk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid;
			r = bresp;
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tb) break;
		end
		bready <= 1'b0;
		if (n == 40) tmo();
		@(posedge aclk);
	endtask : wr

	task automatic rd(input logic [7:0] a);
		int n;
		logic ta, tr;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(negedge aclk);
			ta = arvalid && arready;
			tr = rvalid;
			v = rdata;
			r = rresp;
			@(posedge aclk);
			if (ta) arvalid <= 1'b0;
			if (tr) break;
		end
		rready <= 1'b0;
		if (n == 40) tmo();
		@(posedge aclk);
	endtask : rd

	// Wait for the busy flag to drop, bounded
	task automatic poll;
		int n;
		for (n = 0; n < 20; n++) begin
			rd(`SBN_OFS_STATUS);
			if (v[`SBN_ST_BUSY] === 1'b0) break;
		end
		if (n == 20) tmo();
	endtask : poll

	task automatic reset_dut;
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
	endtask : reset_dut

	initial begin
		err_count = 0;
		check_count = 0;
		{awvalid, wvalid, bready, arvalid, rready} <= 5'h00;
		{awaddr, araddr, wdata} <= 48'h0000_0000_0000;
		wstrb <= 4'hF;
		reset_dut();
		// Table rows: set up, run one instruction, check both destinations
		foreach (rows[k]) begin
			ad = rows[k].i[8] ? {rows[k].b[3:0], rows[k].i[7:0]} : {4'h0, rows[k].i[7:0]};
			wr(`SBN_OFS_MADDR, 32'(ad));
			wr(`SBN_OFS_MDATA, 32'(rows[k].f));
			wr(`SBN_OFS_ACC, 32'(rows[k].w));
			wr(`SBN_OFS_BANK, 32'(rows[k].b));
			wr(`SBN_OFS_STATUS, 32'(rows[k].s));
			wr(`SBN_OFS_INSTR, 32'(rows[k].i));
			chkr(r, `SBN_RESP_OKAY);
			rd(`SBN_OFS_STATUS);
			chk(v & 32'h0000_0100, 32'h0000_0100);
			poll();
			rd(`SBN_OFS_ACC);
			chk(v, 32'(rows[k].i[9] ? rows[k].w : rows[k].x));
			rd(`SBN_OFS_MDATA);
			chk(v, 32'(rows[k].i[9] ? rows[k].x : rows[k].f));
			rd(`SBN_OFS_STATUS);
			chk(v, 32'(rows[k].y));
			$display("row %0d done", k);
		end
		// Write while an instruction is in flight is refused
		wr(`SBN_OFS_INSTR, 32'h0000_5A10);
		wr(`SBN_OFS_ACC, 32'h0000_0022);
		chkr(r, `SBN_RESP_SLVERR);
		poll();
		rd(`SBN_OFS_ACC);
		// Last row left the swapped byte in the accumulator; d=1 result goes to the file
		chk(v, 32'h0000_005A);
		// Opcode outside both encodings writes nothing
		wr(`SBN_OFS_INSTR, 32'h0000_FC10);
		poll();
		rd(`SBN_OFS_STATUS);
		chk(v & 32'h0000_0200, 32'h0000_0200);
		rd(`SBN_OFS_ACC);
		chk(v, 32'h0000_005A);
		// Unmapped place
		rd(8'h40);
		chk(v, 32'h0000_0000);
		chkr(r, `SBN_RESP_SLVERR);
		wr(8'h40, 32'h0000_00FF);
		chkr(r, `SBN_RESP_SLVERR);
		$display("awkward cases done");
		// Second reset clears registers
		reset_dut();
		rd(`SBN_OFS_ACC);
		chk(v, 32'h0000_0000);
		rd(`SBN_OFS_STATUS);
		chk(v, 32'h0000_0000);
		rd(`SBN_OFS_BANK);
		chk(v, 32'h0000_0000);
		$display("reset case done");
		finish_test();
	end
endmodule : tb_top
